/* File: logic/adc_pkg.sv */
package adc_pkg;

  // result word and buffering
  localparam int WORD_W     = 24;
  localparam int FIFO_DEPTH = 16;
  localparam int CNT_W      = 16;
  localparam int BITCNT_W   = 5;
  localparam logic [BITCNT_W-1:0] BITS_PER_WORD = 5'h18;
  localparam logic [BITCNT_W-1:0] BITCNT_ZERO   = 5'h00;
  localparam logic [BITCNT_W-1:0] BITCNT_ONE    = 5'h01;

  // clock and timing figures
  localparam int MCLK_PERIOD_NS   = 40;
  localparam int CS_TRISTATE_NS   = 8;
  localparam int CS_SETUP_NS      = 5;
  localparam int SCLK_GUARD_MCLK  = 3;
  // longest time, rounded down, but never below one cycle
  localparam int CS_TRISTATE_CYC  = (CS_TRISTATE_NS / MCLK_PERIOD_NS) < 1 ? 1 :
                                    (CS_TRISTATE_NS / MCLK_PERIOD_NS);
  // internal shift clock half period, in master clock cycles
  localparam logic [7:0] SCLK_HALF_CYC = 8'h01;

  // conversion lengths in master clock cycles at the slowest rate
  localparam logic [CNT_W-1:0] SETTLE_WIDE_BW  = 16'h0100;
  localparam logic [CNT_W-1:0] SETTLE_LL_SINGLE = 16'h0200;
  localparam logic [CNT_W-1:0] SETTLE_LL_FAST   = 16'h0080;
  localparam logic [CNT_W-1:0] SETTLE_MIN       = 16'h0001;
  localparam logic [CNT_W-1:0] CNT_ONE          = 16'h0001;

  // positions inside the synchronised pin vector
  localparam int PIN_W        = 9;
  localparam int PIN_START    = 0;
  localparam int PIN_CS_N     = 1;
  localparam int PIN_SCLK     = 2;
  localparam int PIN_SCLK_SEL = 3;
  localparam int PIN_ROUTE    = 4;
  localparam int PIN_LOWLAT   = 5;
  localparam int PIN_IFACE    = 6;
  localparam int PIN_RATE_LO  = 7;
  localparam int PIN_RATE_HI  = 8;

  typedef enum logic [1:0] {CV_IDLE, CV_RUN, CV_HOLD} conv_state_t;
  typedef enum logic [1:0] {SH_IDLE, SH_LOAD, SH_SHIFT} shift_state_t;

endpackage : adc_pkg

/* File: logic/sample_fifo.sv */
`timescale 1ns/1ps
module sample_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 16
) (
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic             wr_valid,
  output logic                  wr_ready,
  input  wire logic [WIDTH-1:0] wr_data,
  output logic                  rd_valid,
  input  wire logic             rd_ready,
  output logic [WIDTH-1:0]      rd_data
);

  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wptr;
    logic [AW-1:0]               rptr;
    logic [AW:0]                 count;
  } fifo_st_t;

  fifo_st_t s_q;
  fifo_st_t s_d;
  logic     do_wr;
  logic     do_rd;

  assign wr_ready = (s_q.count != DEPTH[AW:0]);
  assign rd_valid = (s_q.count != '0);
  assign rd_data  = s_q.mem[s_q.rptr];
  assign do_wr    = wr_valid && wr_ready;
  assign do_rd    = rd_valid && rd_ready;

  always_comb begin
    s_d = s_q;
    if (do_wr) begin
      s_d.mem[s_q.wptr] = wr_data;
      s_d.wptr          = (s_q.wptr == AW'(DEPTH - 1)) ? '0 : s_q.wptr + 1'b1;
    end
    if (do_rd) begin
      s_d.rptr = (s_q.rptr == AW'(DEPTH - 1)) ? '0 : s_q.rptr + 1'b1;
    end
    if (do_wr && !do_rd) begin
      s_d.count = s_q.count + 1'b1;
    end else if (do_rd && !do_wr) begin
      s_d.count = s_q.count - 1'b1;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

endmodule : sample_fifo

/* File: logic/adc_readout.sv */
// How it works
// - low-latency select picks single-cycle or fast settling
// - route select: 0 wide-bandwidth, 1 low-latency
// - start launches, restarts and synchronises conversions
// - chip select high floats serial data output
// - positive shift clock driven only when internal
// - negative shift clock complements internal, else floats
// - new data bit after each shift clock rise but the first, which repeats the msb
// - start sampled on master clock rising edge
// - restart mid-conversion discards data, starts afresh
// - interface select: 0 differential, 1 single-ended
// - clock source select: internal or host clock
`timescale 1ns/1ps
module adc_readout #(
  parameter int FIFO_DEPTH = adc_pkg::FIFO_DEPTH
) (
  input  wire logic                        mclk,
  input  wire logic                        reset_n,
  input  wire logic                        start,
  input  wire logic                        cs_n,
  input  wire logic                        sclk_sel,
  input  wire logic                        iface_cmos_select,
  input  wire logic                        filter_route_select,
  input  wire logic                        lowlat_settle_select,
  input  wire logic [1:0]                  output_rate_select,
  input  wire logic                        sclk_in,
  input  wire logic [adc_pkg::WORD_W-1:0]  sample_data,
  input  wire logic                        sample_overrange,
  output logic                             sclk_p_out,
  output logic                             sclk_p_oe,
  output logic                             sclk_n_out,
  output logic                             sclk_n_oe,
  output logic                             dout_p,
  output logic                             dout_n,
  output logic                             dout_oe,
  output logic                             result_ready_strobe,
  output logic                             result_ready_strobe_n,
  output logic                             diff_pins_enable,
  output logic                             range_exceeded_flag,
  output logic                             wide_path_enable,
  output logic                             lowlat_path_enable,
  output logic                             single_cycle_settle,
  output logic                             conversion_busy
);

  typedef struct packed {
    logic [adc_pkg::PIN_W-1:0]    meta;
    logic [adc_pkg::PIN_W-1:0]    sync;
    logic                         start_prev;
    logic                         sclk_prev;
    adc_pkg::conv_state_t         cv;
    logic [adc_pkg::CNT_W-1:0]    cnt;
    logic [adc_pkg::WORD_W-1:0]   result;
    logic                         push;
    adc_pkg::shift_state_t        sh;
    logic [adc_pkg::WORD_W-1:0]   shreg;
    logic [adc_pkg::BITCNT_W-1:0] bitcnt;
    logic [7:0]                   div;
    logic                         sclk_int;
    logic                         pop;
    logic                         dout;
    logic                         dout_n;
    logic                         dout_oe;
    logic                         strobe;
    logic                         strobe_n;
    logic                         sclk_p;
    logic                         sclk_p_oe;
    logic                         sclk_n;
    logic                         sclk_n_oe;
    logic                         diff_en;
    logic                         range_flag;
    logic                         wide_en;
    logic                         lowlat_en;
    logic                         single_settle;
    logic                         busy;
  } st_t;

  st_t s_q;
  st_t s_d;

  logic                         fifo_wr_ready;
  logic                         fifo_rd_valid;
  logic [adc_pkg::WORD_W-1:0]   fifo_rd_data;
  logic [adc_pkg::PIN_W-1:0]    pins;

  assign pins[adc_pkg::PIN_START]    = start;
  assign pins[adc_pkg::PIN_CS_N]     = cs_n;
  assign pins[adc_pkg::PIN_SCLK]     = sclk_in;
  assign pins[adc_pkg::PIN_SCLK_SEL] = sclk_sel;
  assign pins[adc_pkg::PIN_ROUTE]    = filter_route_select;
  assign pins[adc_pkg::PIN_LOWLAT]   = lowlat_settle_select;
  assign pins[adc_pkg::PIN_IFACE]    = iface_cmos_select;
  assign pins[adc_pkg::PIN_RATE_LO]  = output_rate_select[0];
  assign pins[adc_pkg::PIN_RATE_HI]  = output_rate_select[1];

  // conversion length from the filter path, settling variant and rate
  function automatic logic [adc_pkg::CNT_W-1:0] settle_len(
    input logic       route_ll,
    input logic       ll_fast,
    input logic [1:0] rate
  );
    logic [adc_pkg::CNT_W-1:0] base;
    logic [adc_pkg::CNT_W-1:0] len;
    base = adc_pkg::SETTLE_WIDE_BW;
    if (route_ll) begin
      base = ll_fast ? adc_pkg::SETTLE_LL_FAST : adc_pkg::SETTLE_LL_SINGLE;
    end
    len = base >> rate;
    if (len < adc_pkg::SETTLE_MIN) begin
      len = adc_pkg::SETTLE_MIN;
    end
    return len;
  endfunction : settle_len

  always_comb begin
    logic                      start_lvl;
    logic                      start_rise;
    logic                      ext_clk;
    logic                      sclk_rise;
    logic                      sclk_fall;
    logic                      lvds_mode;
    logic [1:0]                rate;
    logic [adc_pkg::CNT_W-1:0] len;
    s_d        = s_q;
    start_lvl  = s_q.sync[adc_pkg::PIN_START];
    ext_clk    = s_q.sync[adc_pkg::PIN_SCLK_SEL];
    lvds_mode  = !s_q.sync[adc_pkg::PIN_IFACE];
    rate       = {s_q.sync[adc_pkg::PIN_RATE_HI], s_q.sync[adc_pkg::PIN_RATE_LO]};
    len        = settle_len(s_q.sync[adc_pkg::PIN_ROUTE], s_q.sync[adc_pkg::PIN_LOWLAT], rate);
    start_rise = 1'b0;
    sclk_rise  = 1'b0;
    sclk_fall  = 1'b0;

    // first stage feeds only the second
    s_d.meta       = pins;
    s_d.sync       = s_q.meta;
    s_d.start_prev = start_lvl;
    s_d.sclk_prev  = s_q.sync[adc_pkg::PIN_SCLK];
    start_rise     = start_lvl && !s_q.start_prev;

    // static path selects
    // levels only: the filters themselves sit outside this block
    s_d.wide_en       = !s_q.sync[adc_pkg::PIN_ROUTE];
    s_d.lowlat_en     = s_q.sync[adc_pkg::PIN_ROUTE];
    s_d.single_settle = !s_q.sync[adc_pkg::PIN_LOWLAT];

    // conversion sequencer
    unique case (s_q.cv)
      adc_pkg::CV_IDLE: begin
        if (start_rise) begin
          s_d.cv  = adc_pkg::CV_RUN;
          s_d.cnt = len;
        end
      end
      adc_pkg::CV_RUN: begin
        // the word is taken only on the last count, so a restart just reloads
        if (start_rise) begin
          s_d.cnt = len;
        end else if (s_q.cnt == adc_pkg::CNT_ONE) begin
          s_d.result     = sample_data;
          s_d.range_flag = sample_overrange;
          s_d.push       = 1'b1;
          s_d.cv         = adc_pkg::CV_HOLD;
        end else begin
          s_d.cnt = s_q.cnt - adc_pkg::CNT_ONE;
        end
      end
      adc_pkg::CV_HOLD: begin
        // a full buffer holds the finished word and stalls the next conversion
        if (fifo_wr_ready) begin
          s_d.push = 1'b0;
          if (start_lvl) begin
            s_d.cv  = adc_pkg::CV_RUN;
            s_d.cnt = len;
          end else begin
            s_d.cv = adc_pkg::CV_IDLE;
          end
        end
      end
      default: begin
        s_d.cv = adc_pkg::CV_IDLE;
      end
    endcase
    s_d.busy = (s_d.cv != adc_pkg::CV_IDLE);

    // shift clock events
    // host edges arrive three edges late, so the host clock must stay slow
    if (ext_clk) begin
      sclk_rise = s_q.sync[adc_pkg::PIN_SCLK] && !s_q.sclk_prev;
      sclk_fall = !s_q.sync[adc_pkg::PIN_SCLK] && s_q.sclk_prev;
    end else if (s_q.sh == adc_pkg::SH_SHIFT) begin
      if (s_q.div == 8'h00) begin
        s_d.div      = adc_pkg::SCLK_HALF_CYC - 8'h01;
        s_d.sclk_int = !s_q.sclk_int;
        sclk_rise    = !s_q.sclk_int;
        sclk_fall    = s_q.sclk_int;
      end else begin
        s_d.div = s_q.div - 8'h01;
      end
    end

    // readout sequencer
    s_d.strobe = 1'b0;
    s_d.pop    = 1'b0;
    unique case (s_q.sh)
      adc_pkg::SH_IDLE: begin
        s_d.sclk_int = 1'b0;
        s_d.div      = adc_pkg::SCLK_HALF_CYC - 8'h01;
        // the registered pop lands with the load, which takes the head word before it moves
        if (fifo_rd_valid) begin
          s_d.pop = 1'b1;
          s_d.sh  = adc_pkg::SH_LOAD;
        end
      end
      adc_pkg::SH_LOAD: begin
        s_d.shreg  = fifo_rd_data;
        s_d.dout   = fifo_rd_data[adc_pkg::WORD_W-1];
        s_d.bitcnt = adc_pkg::BITCNT_ZERO;
        s_d.strobe = 1'b1;
        s_d.sh     = adc_pkg::SH_SHIFT;
      end
      adc_pkg::SH_SHIFT: begin
        // the first rise shows the msb again, so 24 rises pair with 24 falls
        if (sclk_rise && (s_q.bitcnt != adc_pkg::BITS_PER_WORD)) begin
          s_d.dout   = s_q.shreg[adc_pkg::WORD_W-1];
          s_d.shreg  = {s_q.shreg[adc_pkg::WORD_W-2:0], 1'b0};
          s_d.bitcnt = s_q.bitcnt + adc_pkg::BITCNT_ONE;
        end else if (sclk_fall && (s_q.bitcnt == adc_pkg::BITS_PER_WORD)) begin
          // a host clock must stop here, well ahead of the next strobe
          s_d.sh       = adc_pkg::SH_IDLE;
          s_d.sclk_int = 1'b0;
        end
      end
      default: begin
        s_d.sh = adc_pkg::SH_IDLE;
      end
    endcase

    // pin drivers
    // selects act three edges after the pin moves
    s_d.dout_oe   = !s_q.sync[adc_pkg::PIN_CS_N];
    s_d.sclk_p    = s_d.sclk_int;
    s_d.sclk_p_oe = !ext_clk;
    s_d.sclk_n    = ext_clk ? 1'b0 : !s_d.sclk_int;
    s_d.sclk_n_oe = !ext_clk;
    s_d.diff_en   = lvds_mode;
    s_d.dout_n    = lvds_mode ? !s_d.dout : 1'b0;
    s_d.strobe_n  = lvds_mode ? !s_d.strobe : 1'b0;
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      // selects wake on the quiet side, deselected and host-clocked, so no
      // pin is driven before the synchronisers hold the real levels
      s_q                             <= '0;
      s_q.meta[adc_pkg::PIN_CS_N]     <= 1'b1;
      s_q.sync[adc_pkg::PIN_CS_N]     <= 1'b1;
      s_q.meta[adc_pkg::PIN_SCLK_SEL] <= 1'b1;
      s_q.sync[adc_pkg::PIN_SCLK_SEL] <= 1'b1;
      s_q.cv                          <= adc_pkg::CV_IDLE;
      s_q.sh                          <= adc_pkg::SH_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  // the buffer lets conversions run on while a slow host reads
  sample_fifo #(
    .WIDTH (adc_pkg::WORD_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk      (mclk),
    .reset_n  (reset_n),
    .wr_valid (s_q.push),
    .wr_ready (fifo_wr_ready),
    .wr_data  (s_q.result),
    .rd_valid (fifo_rd_valid),
    .rd_ready (s_q.pop),
    .rd_data  (fifo_rd_data)
  );

  // every output is a register bit; nothing combinational reaches a pin
  assign sclk_p_out            = s_q.sclk_p;
  assign sclk_p_oe             = s_q.sclk_p_oe;
  assign sclk_n_out            = s_q.sclk_n;
  assign sclk_n_oe             = s_q.sclk_n_oe;
  assign dout_p                = s_q.dout;
  assign dout_n                = s_q.dout_n;
  assign dout_oe               = s_q.dout_oe;
  assign result_ready_strobe   = s_q.strobe;
  assign result_ready_strobe_n = s_q.strobe_n;
  assign diff_pins_enable      = s_q.diff_en;
  assign range_exceeded_flag   = s_q.range_flag;
  assign wide_path_enable      = s_q.wide_en;
  assign lowlat_path_enable    = s_q.lowlat_en;
  assign single_cycle_settle   = s_q.single_settle;
  assign conversion_busy       = s_q.busy;

endmodule : adc_readout

/* File: sim/adc_readout_checker.sv */
`timescale 1ns/1ps
module adc_readout_checker (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic start,
  input wire logic cs_n,
  input wire logic sclk_sel,
  input wire logic iface_cmos_select,
  input wire logic filter_route_select,
  input wire logic sclk_p_out,
  input wire logic sclk_p_oe,
  input wire logic sclk_n_out,
  input wire logic sclk_n_oe,
  input wire logic dout_p,
  input wire logic dout_n,
  input wire logic dout_oe,
  input wire logic result_ready_strobe,
  input wire logic result_ready_strobe_n,
  input wire logic diff_pins_enable,
  input wire logic wide_path_enable,
  input wire logic lowlat_path_enable,
  input wire logic conversion_busy
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  // pins pass a 2FF stage and a register, so settle windows are four edges
  AST_WIDE_PATH: assert property (
    $stable(filter_route_select)[*4] |-> wide_path_enable == !filter_route_select)
    else $error("wide path enable wrong");
  AST_LOWLAT_PATH: assert property (
    $stable(filter_route_select)[*4] |-> lowlat_path_enable == filter_route_select)
    else $error("low latency path enable wrong");
  AST_IFACE: assert property (
    $stable(iface_cmos_select)[*4] |-> diff_pins_enable == !iface_cmos_select
      && dout_n == (!iface_cmos_select && !dout_p))
    else $error("signalling mode wrong");
  AST_SCLK_DIR: assert property (
    $stable(sclk_sel)[*4] |-> sclk_p_oe == !sclk_sel && sclk_n_oe == !sclk_sel
      && (sclk_sel || sclk_n_out != sclk_p_out))
    else $error("shift clock pins wrong");
  AST_CS_FLOAT: assert property (
    $stable(cs_n)[*4] |-> dout_oe == !cs_n)
    else $error("data output enable wrong");
  AST_STROBE_PULSE: assert property (
    result_ready_strobe |=> !result_ready_strobe)
    else $error("ready strobe longer than one cycle");
  AST_STROBE_COMP: assert property (
    $stable(iface_cmos_select)[*4] |-> result_ready_strobe_n
      == (!iface_cmos_select && !result_ready_strobe))
    else $error("ready strobe complement wrong");
  AST_DOUT_HOLD: assert property (
    (!sclk_sel)[*4] ##1 $changed(dout_p) |-> $rose(sclk_p_out) || result_ready_strobe)
    else $error("data moved without shift clock rise");
  AST_START_TAKEN: assert property (
    $rose(start) && !conversion_busy |-> ##[1:6] conversion_busy)
    else $error("start not taken");
  COV_INT: cover property ((!sclk_sel)[*4] ##1 result_ready_strobe);
  COV_EXT: cover property (sclk_sel[*4] ##1 result_ready_strobe);
  COV_RESTART: cover property ($rose(start) && conversion_busy);
endmodule : adc_readout_checker

bind adc_readout adc_readout_checker i_chk (
  .mclk, .reset_n, .start, .cs_n, .sclk_sel, .iface_cmos_select, .filter_route_select,
  .sclk_p_out, .sclk_p_oe, .sclk_n_out, .sclk_n_oe, .dout_p, .dout_n, .dout_oe,
  .result_ready_strobe, .result_ready_strobe_n, .diff_pins_enable, .wide_path_enable,
  .lowlat_path_enable, .conversion_busy
);

/* File: sim/host_reader.sv */
`timescale 1ns/1ps
module host_reader (
  input  wire logic        mclk,
  input  wire logic        sclk_sel,
  input  wire logic        stall,
  input  wire logic        strobe,
  input  wire logic        sclk_p,
  input  wire logic        dout,
  output logic             sclk_in,
  output logic [23:0]      word,
  output logic [7:0]       count
);
  logic [23:0] shift_q;
  int          bits = 0;
  wire         shift_clk = sclk_sel ? sclk_in : sclk_p;
  initial begin
    sclk_in = 1'h0;
    count = 8'h00;
    word = 24'h000000;
  end
  // clock only inside a frame; odd offset keeps it out of phase with mclk
  always @(posedge mclk) begin
    if (strobe) begin
      bits = 0;
      if (sclk_sel) begin
        wait (!stall);
        #7;
        repeat (24) begin
          #160 sclk_in = 1'h1;
          #160 sclk_in = 1'h0;
        end // last fall precedes the next strobe
      end
    end
  end
  // sample on the falling edge, data moves after the rising one
  always @(negedge shift_clk) begin
    shift_q = {shift_q[22:0], dout};
    bits++;
    if (bits == 24) begin
      word = shift_q;
      count = count + 8'h01;
    end
  end
endmodule : host_reader

/* File: sim/test_adc_readout.sv */
`timescale 1ns/1ps
module test_adc_readout;
  logic mclk = 1'h0;
  logic reset_n, start, cs_n, sclk_sel, iface_cmos_select, filter_route_select;
  logic lowlat_settle_select, sclk_in, sample_overrange, stall;
  logic [1:0] output_rate_select;
  logic [adc_pkg::WORD_W-1:0] sample_data, host_word;
  logic [7:0] host_count;
  logic sclk_p_out, sclk_p_oe, sclk_n_out, sclk_n_oe, dout_p, dout_n, dout_oe;
  logic result_ready_strobe, result_ready_strobe_n, diff_pins_enable, range_exceeded_flag;
  logic wide_path_enable, lowlat_path_enable, single_cycle_settle, conversion_busy;
  int miscompares = 0;
  int comparisons = 0;
  int cycles = 0;
  logic [adc_pkg::WORD_W-1:0] exp_q[$];
  adc_readout i_dut (
    .mclk, .reset_n, .start, .cs_n, .sclk_sel, .iface_cmos_select, .filter_route_select,
    .lowlat_settle_select, .output_rate_select, .sclk_in, .sample_data, .sample_overrange,
    .sclk_p_out, .sclk_p_oe, .sclk_n_out, .sclk_n_oe, .dout_p, .dout_n, .dout_oe,
    .result_ready_strobe, .result_ready_strobe_n, .diff_pins_enable, .range_exceeded_flag,
    .wide_path_enable, .lowlat_path_enable, .single_cycle_settle, .conversion_busy
  );
  host_reader i_host (
    .mclk, .sclk_sel, .stall, .strobe(result_ready_strobe), .sclk_p(sclk_p_out),
    .dout(dout_p), .sclk_in, .word(host_word), .count(host_count)
  );
  always #20 mclk = ~mclk;
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 60000) begin
      miscompares++;
      end_of_test();
    end
  end
  task automatic tick(input int n = 1);
    repeat (n) @(posedge mclk);
    #2;
  endtask : tick
  task automatic fail(input string msg);
    miscompares++;
    $display("unexpected at %0t: %s", $time, msg);
  endtask : fail
  task automatic chk_word(input logic [23:0] got, input logic [23:0] exp);
    comparisons++;
    if (got !== exp) fail($sformatf("word %h want %h", got, exp));
  endtask : chk_word
  task automatic chk_bit(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) fail($sformatf("level %b want %b", got, exp));
  endtask : chk_bit
  task automatic chk_range(input int got, input int lo, input int hi);
    comparisons++;
    if (got < lo || got > hi) fail($sformatf("count %0d not in %0d..%0d", got, lo, hi));
  endtask : chk_range
  task automatic get_word(output bit ok);
    logic [7:0] c0;
    int n;
    c0 = host_count;
    n = 0;
    while (host_count === c0 && n < 3000) begin
      tick();
      n++;
    end
    ok = host_count !== c0;
  endtask : get_word
  // one conversion, optionally cutting short an earlier start that must be discarded
  task automatic convert(input bit restart);
    logic [23:0] d;
    logic ovr;
    int len, n;
    bit ok;
    len = int'(filter_route_select ? (lowlat_settle_select ? adc_pkg::SETTLE_LL_FAST
      : adc_pkg::SETTLE_LL_SINGLE) : adc_pkg::SETTLE_WIDE_BW) >> output_rate_select;
    if (restart) begin
      sample_data = 24'($urandom());
      start = 1'h1;
      tick(2);
      start = 1'h0;
      tick(len / 2);
    end
    d = 24'($urandom());
    ovr = 1'($urandom());
    sample_data = d;
    sample_overrange = ovr;
    exp_q.push_back(d);
    start = 1'h1;
    tick(2);
    start = 1'h0;
    n = 2;
    while (result_ready_strobe !== 1'h1 && n < 1000) begin
      tick();
      n++;
    end
    chk_range(n, len + 2, len + 12);
    get_word(ok);
    chk_word(host_word, exp_q.pop_front());
    chk_bit(range_exceeded_flag, ovr);
  endtask : convert
  task automatic end_of_test();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_of_test
  initial begin
    int n;
    bit ok;
    void'($urandom(32'hDB66));
    {reset_n, start, sclk_sel, iface_cmos_select, stall, sample_overrange} = '0;
    {filter_route_select, lowlat_settle_select, output_rate_select} = 4'h0;
    sample_data = 24'h000000;
    cs_n = 1'h1;
    tick(12);
    reset_n = 1'h1;
    tick(6);
    chk_bit(dout_oe, 1'h0);
    cs_n = 1'h0;
    tick(6);
    chk_bit(dout_oe, 1'h1);
    for (int c = 0; c < 16; c++) begin
      {filter_route_select, lowlat_settle_select, output_rate_select} = 4'(c);
      sclk_sel = c[0] ^ c[2];
      iface_cmos_select = c[1] ^ c[3];
      tick(6);
      chk_bit(wide_path_enable, !c[3]);
      chk_bit(single_cycle_settle, !c[2]);
      convert(c[0] & c[1]);
    end
    // host stalls with start held: fifo fills, conversions wait, nothing lost
    sclk_sel = 1'h1;
    stall = 1'h1;
    sample_data = 24'($urandom());
    tick(6);
    start = 1'h1;
    tick(640);
    start = 1'h0;
    chk_bit(conversion_busy, 1'h1);
    stall = 1'h0;
    n = 0;
    ok = 1'b1;
    while (ok) begin
      get_word(ok);
      if (ok) begin
        chk_word(host_word, sample_data);
        n++;
      end
    end
    chk_range(n, adc_pkg::FIFO_DEPTH + 1, adc_pkg::FIFO_DEPTH + 3);
    end_of_test();
  end
endmodule : test_adc_readout
